// ==== shared/csc_defines.svh ====
// constants of the clock source controller
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

// task strobe positions
`define CSC_TASK_XTAL_START 0
`define CSC_TASK_XTAL_STOP 1
`define CSC_TASK_SLOW_START 2
`define CSC_TASK_SLOW_STOP 3
`define CSC_TASK_CAL 4
`define CSC_TASK_CT_START 5
`define CSC_TASK_CT_STOP 6
`define CSC_NUM_TASKS 7

// event flag positions
`define CSC_EV_XTAL_STARTED 0
`define CSC_EV_SLOW_STARTED 1
`define CSC_EV_CAL_DONE 2
`define CSC_EV_CT_TIMEOUT 3
`define CSC_NUM_EVENTS 4

// slow source field codes
`define CSC_SRC_RC 2'h0
`define CSC_SRC_XTAL 2'h1
`define CSC_SRC_SYNTH 2'h2

// fast branch positions
`define CSC_BR_CPU_64M 0
`define CSC_BR_PER_1M 1
`define CSC_BR_PER_16M 2
`define CSC_BR_PER_32M 3
`define CSC_NUM_BRANCHES 4

// calibration length in slow clock periods, timer width
`define CSC_CAL_SLOW_PERIODS 16
`define CSC_CT_WIDTH 7

`endif

// ==== shared/csc_pkg.sv ====
// types of the clock source controller
package csc_pkg;

	typedef enum logic [1:0] {
		CSC_XT_OFF = 2'h0,
		CSC_XT_STARTING = 2'h1,
		CSC_XT_RUNNING = 2'h3
	} csc_xtal_state_t;

	typedef enum logic [1:0] {
		CSC_SL_OFF = 2'h0,
		CSC_SL_STARTING = 2'h1,
		CSC_SL_RUNNING = 2'h3
	} csc_slow_state_t;

endpackage : csc_pkg

// ==== rtl/csc_sync.sv ====
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module csc_sync (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic async_i,
	output logic sync_o
);
	logic meta_r;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule : csc_sync

// ==== rtl/csc_clock_ctrl.sv ====
// clock source controller: fast branches, slow source, calibration and timer
//
// What this block does
// (RULE_01) requested fast branches are supplied automatically
// (RULE_02) no requests puts fast controller asleep
// (RULE_03) fast clocks only in ON, internal starts
// (RULE_04) internal oscillator serves until crystal started
// (RULE_05) crystal start and stop tasks
// (RULE_06) crystal started event once stable
// (RULE_07) software starts crystal before radio or calibration
// (RULE_08) software selects source before slow start
// (RULE_09) crystal source runs from RC until ready
// (RULE_10) slow started event after startup
// (RULE_11) source select not written while running
// (RULE_12) slow stop only after running state
// (RULE_13) OFF mode holds slow domain off
// (RULE_14) calibrate task calibrates RC using fast clock
// (RULE_15) calibration done event when finished
// (RULE_16) RC not stopped during calibration
// (RULE_17) timer counts down, times out, stops
// (RULE_18) one calibration task per slow period
// (RULE_19) source codes RC, crystal, synth
// (RULE_20) external and bypass combinations for crystal
// (RULE_21) synth source keeps fast clock requested
// (RULE_22) task triggers on writing one
// (RULE_23) sticky events drive interrupt when enabled
`include "csc_defines.svh"
`timescale 1ns/1ps
module csc_clock_ctrl import csc_pkg::*; #(
	parameter int CT_WIDTH = `CSC_CT_WIDTH,
	parameter int CAL_SLOW_PERIODS = `CSC_CAL_SLOW_PERIODS
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic system_on_i,
	input wire logic [`CSC_NUM_BRANCHES-1:0] branch_req_i,
	input wire logic [`CSC_NUM_TASKS-1:0] task_wr_i,
	input wire logic [31:0] task_wdata_i,
	input wire logic [1:0] slow_source_select_i,
	input wire logic slow_external_i,
	input wire logic slow_bypass_i,
	input wire logic [CT_WIDTH-1:0] cal_timer_interval_i,
	input wire logic [`CSC_NUM_EVENTS-1:0] event_clr_i,
	input wire logic [`CSC_NUM_EVENTS-1:0] int_enable_i,
	input wire logic fast_xtal_stable_i,
	input wire logic slow_rc_ready_i,
	input wire logic slow_xtal_ready_i,
	input wire logic slow_clock_i,
	output logic [`CSC_NUM_BRANCHES-1:0] branch_en_o,
	output logic fast_active_o,
	output logic fast_internal_osc_en_o,
	output logic fast_crystal_osc_en_o,
	output logic fast_src_xtal_o,
	output logic slow_rc_osc_en_o,
	output logic slow_crystal_osc_en_o,
	output logic slow_synth_en_o,
	output logic [1:0] slow_src_active_o,
	output logic [1:0] slow_src_copy_o,
	output logic slow_xtal_external_o,
	output logic slow_xtal_bypass_o,
	output logic slow_running_o,
	output logic cal_busy_o,
	output logic cal_timer_running_o,
	output logic [`CSC_NUM_EVENTS-1:0] events_o,
	output logic irq_o
);
	// (RULE_22) a task fires only when bit 0 of the written value is one
	function automatic logic task_hit(input logic [`CSC_NUM_TASKS-1:0] wr,
		input logic [31:0] data, input int idx);
		task_hit = wr[idx] & data[0];
	endfunction : task_hit

	csc_xtal_state_t xt_state_r;
	csc_slow_state_t sl_state_r;
	logic xtal_stable_s;
	logic rc_ready_s;
	logic lxtal_ready_s;
	logic slow_clk_s;
	logic slow_clk_d_r;
	logic slow_tick;
	logic on_d_r;
	logic on_entry;
	logic [1:0] src_r;
	logic ext_r;
	logic byp_r;
	logic on_xtal_r;
	logic cal_r;
	logic [7:0] cal_cnt_r;
	logic ct_run_r;
	logic [CT_WIDTH-1:0] ct_cnt_r;
	logic [`CSC_NUM_EVENTS-1:0] ev_set;
	logic [`CSC_NUM_EVENTS-1:0] ev_r;
	logic fast_need;
	logic t_xstart;
	logic t_xstop;
	logic t_sstart;
	logic t_sstop;
	logic t_cal;
	logic t_cal_timer_start_task;
	logic t_cal_timer_stop_task;

	csc_sync u_sync_xtal (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.async_i(fast_xtal_stable_i), .sync_o(xtal_stable_s));
	csc_sync u_sync_rc (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.async_i(slow_rc_ready_i), .sync_o(rc_ready_s));
	csc_sync u_sync_lx (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.async_i(slow_xtal_ready_i), .sync_o(lxtal_ready_s));
	csc_sync u_sync_sclk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.async_i(slow_clock_i), .sync_o(slow_clk_s));

	assign t_xstart = task_hit(task_wr_i, task_wdata_i, `CSC_TASK_XTAL_START);
	assign t_xstop = task_hit(task_wr_i, task_wdata_i, `CSC_TASK_XTAL_STOP);
	assign t_sstart = task_hit(task_wr_i, task_wdata_i, `CSC_TASK_SLOW_START);
	assign t_sstop = task_hit(task_wr_i, task_wdata_i, `CSC_TASK_SLOW_STOP);
	assign t_cal = task_hit(task_wr_i, task_wdata_i, `CSC_TASK_CAL);
	assign t_cal_timer_start_task = task_hit(task_wr_i, task_wdata_i, `CSC_TASK_CT_START);
	assign t_cal_timer_stop_task = task_hit(task_wr_i, task_wdata_i, `CSC_TASK_CT_STOP);

	// slow clock rising edge, seen after the synchroniser
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slow_clk_d_r <= 1'b0;
			on_d_r <= 1'b0;
		end else begin
			slow_clk_d_r <= slow_clk_s;
			on_d_r <= system_on_i;
		end
	end
	assign slow_tick = slow_clk_s & ~slow_clk_d_r & (sl_state_r != CSC_SL_OFF);
	assign on_entry = system_on_i & ~on_d_r;

	// (RULE_05) crystal started and stopped by its tasks
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xt_state_r <= CSC_XT_OFF;
		end else if (!system_on_i || t_xstop) begin
			xt_state_r <= CSC_XT_OFF;
		end else begin
			case (xt_state_r)
				CSC_XT_OFF: begin
					if (t_xstart) begin
						xt_state_r <= CSC_XT_STARTING;
					end
				end
				CSC_XT_STARTING: begin
					if (xtal_stable_s) begin
						xt_state_r <= CSC_XT_RUNNING;
					end
				end
				CSC_XT_RUNNING: begin
					xt_state_r <= CSC_XT_RUNNING;
				end
				default: begin
					xt_state_r <= CSC_XT_OFF;
				end
			endcase
		end
	end

	// (RULE_21) synth source and calibration hold the fast clock up
	assign fast_need = (|branch_req_i) | cal_r |
		((sl_state_r != CSC_SL_OFF) && (src_r == `CSC_SRC_SYNTH));

	// fast branch outputs
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			branch_en_o <= '0;
			fast_active_o <= 1'b0;
			fast_internal_osc_en_o <= 1'b0;
			fast_crystal_osc_en_o <= 1'b0;
			fast_src_xtal_o <= 1'b0;
		end else begin
			// (RULE_01) each requested branch enabled in ON mode
			branch_en_o <= system_on_i ? branch_req_i : '0;
			// (RULE_02) nothing requested means power saving
			fast_active_o <= system_on_i & fast_need;
			// (RULE_03) internal oscillator starts on ON entry
			// (RULE_04) internal oscillator serves until crystal runs
			fast_internal_osc_en_o <= system_on_i & (on_entry | fast_need) &
				(xt_state_r != CSC_XT_RUNNING);
			fast_crystal_osc_en_o <= system_on_i & (xt_state_r != CSC_XT_OFF) & ~t_xstop;
			fast_src_xtal_o <= system_on_i & (xt_state_r == CSC_XT_RUNNING) & ~t_xstop;
		end
	end

	// (RULE_13) slow controller held off outside ON mode
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sl_state_r <= CSC_SL_OFF;
			on_xtal_r <= 1'b0;
		end else if (!system_on_i) begin
			sl_state_r <= CSC_SL_OFF;
			on_xtal_r <= 1'b0;
		end else begin
			case (sl_state_r)
				CSC_SL_OFF: begin
					if (t_sstart) begin
						sl_state_r <= CSC_SL_STARTING;
					end
					on_xtal_r <= 1'b0;
				end
				CSC_SL_STARTING: begin
					// (RULE_09) RC carries the clock until crystal is ready
					if (src_r == `CSC_SRC_XTAL && lxtal_ready_s) begin
						sl_state_r <= CSC_SL_RUNNING;
						on_xtal_r <= 1'b1;
					end else if (src_r == `CSC_SRC_RC && rc_ready_s) begin
						sl_state_r <= CSC_SL_RUNNING;
					end else if (src_r == `CSC_SRC_SYNTH && xt_state_r != CSC_XT_OFF) begin
						sl_state_r <= CSC_SL_RUNNING;
					end else if (src_r == `CSC_SRC_SYNTH && fast_internal_osc_en_o) begin
						sl_state_r <= CSC_SL_RUNNING;
					end
				end
				CSC_SL_RUNNING: begin
					// (RULE_12) stop accepted only in the running state
					if (t_sstop) begin
						sl_state_r <= CSC_SL_OFF;
						on_xtal_r <= 1'b0;
					end
				end
				default: begin
					sl_state_r <= CSC_SL_OFF;
				end
			endcase
		end
	end

	// source copy taken at start, illegal combinations cleaned
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_r <= `CSC_SRC_RC;
			ext_r <= 1'b0;
			byp_r <= 1'b0;
		end else if (t_sstart && sl_state_r == CSC_SL_OFF) begin
			// (RULE_19) codes 0 and 2 force external and bypass clear
			if (slow_source_select_i == `CSC_SRC_XTAL) begin
				src_r <= `CSC_SRC_XTAL;
				ext_r <= slow_external_i;
				// (RULE_20) bypass only honoured with external set
				byp_r <= slow_external_i & slow_bypass_i;
			end else begin
				src_r <= (slow_source_select_i == `CSC_SRC_SYNTH) ? `CSC_SRC_SYNTH
					: `CSC_SRC_RC;
				ext_r <= 1'b0;
				byp_r <= 1'b0;
			end
		end
	end

	// slow source enables
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slow_rc_osc_en_o <= 1'b0;
			slow_crystal_osc_en_o <= 1'b0;
			slow_synth_en_o <= 1'b0;
			slow_src_active_o <= `CSC_SRC_RC;
			slow_src_copy_o <= `CSC_SRC_RC;
			slow_xtal_external_o <= 1'b0;
			slow_xtal_bypass_o <= 1'b0;
			slow_running_o <= 1'b0;
		end else begin
			// (RULE_09) RC enabled for RC source and crystal start-up
			slow_rc_osc_en_o <= (sl_state_r != CSC_SL_OFF) & (src_r != `CSC_SRC_SYNTH) &
				~on_xtal_r;
			slow_crystal_osc_en_o <= (sl_state_r != CSC_SL_OFF) & (src_r == `CSC_SRC_XTAL);
			slow_synth_en_o <= (sl_state_r != CSC_SL_OFF) & (src_r == `CSC_SRC_SYNTH);
			slow_src_active_o <= on_xtal_r ? `CSC_SRC_XTAL
				: ((src_r == `CSC_SRC_SYNTH) ? `CSC_SRC_SYNTH : `CSC_SRC_RC);
			slow_src_copy_o <= src_r;
			slow_xtal_external_o <= ext_r & (src_r == `CSC_SRC_XTAL);
			slow_xtal_bypass_o <= byp_r & (src_r == `CSC_SRC_XTAL);
			slow_running_o <= (sl_state_r == CSC_SL_RUNNING);
		end
	end

	// (RULE_14) calibration of a running RC source
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_r <= 1'b0;
			cal_cnt_r <= 8'h00;
		end else if (sl_state_r != CSC_SL_RUNNING) begin
			cal_r <= 1'b0;
			cal_cnt_r <= 8'h00;
		end else if (!cal_r) begin
			if (t_cal && src_r == `CSC_SRC_RC) begin
				cal_r <= 1'b1;
				cal_cnt_r <= 8'(CAL_SLOW_PERIODS);
			end
		end else if (slow_tick) begin
			cal_cnt_r <= cal_cnt_r - 8'h01;
			if (cal_cnt_r == 8'h01) begin
				cal_r <= 1'b0;
			end
		end
	end

	// (RULE_17) count down from interval, stop at zero
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ct_run_r <= 1'b0;
			ct_cnt_r <= '0;
		end else if (t_cal_timer_start_task) begin
			ct_run_r <= 1'b1;
			ct_cnt_r <= cal_timer_interval_i;
		end else if (t_cal_timer_stop_task || sl_state_r == CSC_SL_OFF) begin
			ct_run_r <= 1'b0;
		end else if (ct_run_r && slow_tick) begin
			if (ct_cnt_r <= CT_WIDTH'(1)) begin
				ct_cnt_r <= '0;
				ct_run_r <= 1'b0;
			end else begin
				ct_cnt_r <= ct_cnt_r - CT_WIDTH'(1);
			end
		end
	end

	// event sources
	always_comb begin
		ev_set = '0;
		// (RULE_06) crystal started once stable
		ev_set[`CSC_EV_XTAL_STARTED] = (xt_state_r == CSC_XT_STARTING) & xtal_stable_s &
			system_on_i & ~t_xstop;
		// (RULE_10) slow start-up complete
		ev_set[`CSC_EV_SLOW_STARTED] = (sl_state_r == CSC_SL_STARTING) & system_on_i &
			(((src_r == `CSC_SRC_XTAL) & lxtal_ready_s) |
			((src_r == `CSC_SRC_RC) & rc_ready_s) |
			((src_r == `CSC_SRC_SYNTH) & ((xt_state_r != CSC_XT_OFF) | fast_internal_osc_en_o)));
		// (RULE_15) calibration finished
		ev_set[`CSC_EV_CAL_DONE] = cal_r & slow_tick & (cal_cnt_r == 8'h01) &
			(sl_state_r == CSC_SL_RUNNING);
		ev_set[`CSC_EV_CT_TIMEOUT] = ct_run_r & slow_tick & (ct_cnt_r <= CT_WIDTH'(1)) &
			~t_cal_timer_start_task & ~t_cal_timer_stop_task & (sl_state_r != CSC_SL_OFF);
	end

	// (RULE_23) sticky flags, set wins over clear, gated interrupt
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ev_r <= '0;
			events_o <= '0;
			irq_o <= 1'b0;
		end else begin
			ev_r <= (ev_r & ~event_clr_i) | ev_set;
			events_o <= (ev_r & ~event_clr_i) | ev_set;
			irq_o <= |(((ev_r & ~event_clr_i) | ev_set) & int_enable_i);
		end
	end

	// status outputs
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cal_busy_o <= 1'b0;
			cal_timer_running_o <= 1'b0;
		end else begin
			cal_busy_o <= cal_r;
			cal_timer_running_o <= ct_run_r;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_xtal_waits;
		xt_state_r == CSC_XT_STARTING && !xtal_stable_s;
	endsequence

	sequence s_xtal_ready;
		xt_state_r == CSC_XT_STARTING && xtal_stable_s && system_on_i && !t_xstop;
	endsequence

	a_branch_follow: assert property (system_on_i |=> branch_en_o == $past(branch_req_i)) // RULE_01
		else $error("branch enable does not follow request");
	a_fast_sleep: assert property (!system_on_i || (branch_req_i == '0 && !cal_r && !slow_synth_en_o
		&& sl_state_r == CSC_SL_OFF) |=> !fast_active_o) // RULE_02
		else $error("fast controller active without request");
	a_on_entry_osc: assert property (on_entry && xt_state_r != CSC_XT_RUNNING
		|=> fast_internal_osc_en_o) // RULE_03
		else $error("internal oscillator not started on entry");
	a_internal_serves: assert property (system_on_i && fast_need && xt_state_r == CSC_XT_OFF
		|=> fast_internal_osc_en_o && !fast_src_xtal_o) // RULE_04
		else $error("internal oscillator not serving");
	a_xtal_stop: assert property (t_xstop |=> xt_state_r == CSC_XT_OFF ##1 !fast_crystal_osc_en_o) // RULE_05
		else $error("crystal not stopped by its task");
	a_xtal_event: assert property (s_xtal_waits |-> !ev_set[`CSC_EV_XTAL_STARTED]) // RULE_06
		else $error("crystal event before stable");
	a_xtal_event_set: assert property (s_xtal_ready |=> ev_r[`CSC_EV_XTAL_STARTED]
		&& events_o[`CSC_EV_XTAL_STARTED]) // RULE_06
		else $error("crystal event missing");
	a_rc_during_xtal: assert property (sl_state_r == CSC_SL_STARTING && src_r == `CSC_SRC_XTAL
		&& system_on_i |=> slow_rc_osc_en_o) // RULE_09
		else $error("rc not running during crystal start-up");
	a_off_mode: assert property (!system_on_i |=> sl_state_r == CSC_SL_OFF ##1
		(!slow_rc_osc_en_o && !slow_crystal_osc_en_o && !slow_synth_en_o)) // RULE_13
		else $error("slow sources alive in off mode");
	a_cal_fast: assert property ($rose(cal_r) && system_on_i |=> fast_active_o) // RULE_14
		else $error("fast clock not raised for calibration");
	a_timer_zero: assert property (ct_run_r && slow_tick && ct_cnt_r == CT_WIDTH'(1) && !t_cal_timer_start_task
		&& !t_cal_timer_stop_task && sl_state_r != CSC_SL_OFF |=> !ct_run_r && ct_cnt_r == '0
		&& ev_r[`CSC_EV_CT_TIMEOUT]) // RULE_17
		else $error("timer did not time out at zero");
	a_src_clean: assert property (src_r != `CSC_SRC_XTAL |-> !ext_r && !byp_r) // RULE_19
		else $error("external or bypass set for non crystal source");
	a_bypass_ext: assert property (byp_r |-> ext_r) // RULE_20
		else $error("bypass without external");
	a_synth_fast: assert property (sl_state_r != CSC_SL_OFF && src_r == `CSC_SRC_SYNTH
		&& system_on_i |=> fast_active_o) // RULE_21
		else $error("synth source without fast clock");
	a_task_zero: assert property (task_wr_i[`CSC_TASK_XTAL_START] && !task_wdata_i[0]
		&& xt_state_r == CSC_XT_OFF |=> xt_state_r == CSC_XT_OFF) // RULE_22
		else $error("task fired on zero write");
	a_event_sticky: assert property (ev_r[`CSC_EV_CAL_DONE] && !event_clr_i[`CSC_EV_CAL_DONE]
		|=> ev_r[`CSC_EV_CAL_DONE] && events_o[`CSC_EV_CAL_DONE]) // RULE_23
		else $error("event flag lost without clear");
	a_irq_gate: assert property (ev_r == '0 && ev_set == '0 |=> !irq_o) // RULE_23
		else $error("interrupt without event");
endmodule : csc_clock_ctrl

// ==== test/csc_osc_model.sv ====
// oscillator model on the far side of the clock controller
`timescale 1ns/1ps
module csc_osc_model #(
	parameter int XT_DLY = 20,
	parameter int RC_DLY = 10,
	parameter int LX_DLY = 40,
	parameter int SLOW_HALF = 8
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic fast_crystal_osc_en_i,
	input wire logic slow_rc_osc_en_i,
	input wire logic slow_crystal_osc_en_i,
	input wire logic slow_synth_en_i,
	output logic fast_xtal_stable_o,
	output logic slow_rc_ready_o,
	output logic slow_xtal_ready_o,
	output logic slow_clock_o
);
	int xt_r;
	int rc_r;
	int lx_r;
	int sl_r;
	logic slow_on;
	assign slow_on = slow_rc_osc_en_i | slow_crystal_osc_en_i | slow_synth_en_i;
	// start-up times; ready drops one clock after the enable goes
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xt_r <= 0;
			rc_r <= 0;
			lx_r <= 0;
		end else begin
			xt_r <= fast_crystal_osc_en_i ? xt_r + 1 : 0;
			rc_r <= slow_rc_osc_en_i ? rc_r + 1 : 0;
			lx_r <= slow_crystal_osc_en_i ? lx_r + 1 : 0;
		end
	end
	assign fast_xtal_stable_o = xt_r >= XT_DLY;
	assign slow_rc_ready_o = rc_r >= RC_DLY;
	assign slow_xtal_ready_o = lx_r >= LX_DLY;
	// slow clock stands low while no slow source is enabled
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i || !slow_on) begin
			sl_r <= 0;
			slow_clock_o <= 1'b0;
		end else if (sl_r == SLOW_HALF - 1) begin
			sl_r <= 0;
			slow_clock_o <= !slow_clock_o;
		end else begin
			sl_r <= sl_r + 1;
		end
	end
endmodule : csc_osc_model

// ==== test/clock_source_controller_tb.sv ====
// self-checking testbench of the clock source controller
`timescale 1ns/1ps
`include "csc_defines.svh"
module clock_source_controller_tb;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic son = 1'b0;
	logic ext = 1'b0;
	logic byp = 1'b0;
	logic [3:0] breq = '0;
	logic [6:0] twr = '0;
	logic [31:0] twd = '0;
	logic [1:0] src = '0;
	logic [6:0] cal_timer_interval = '0;
	logic [3:0] eclr = '0;
	logic [3:0] inten = '0;
	logic xt_st, rc_rdy, lx_rdy, slck, fact, fint, fxt, fsx, rcen, lxen, syen;
	logic xext, xbyp, srun, cbusy, ctrun, irq;
	logic [3:0] ben;
	logic [3:0] ev;
	logic [1:0] sact;
	logic [1:0] scopy;
	int n_fail = 0;
	int n_tests = 0;
	int ncyc = 0;
	int i;
	logic [1:0] t_src [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
	logic [3:0] ext_v = 4'b1011;
	logic [3:0] byp_v = 4'b0111;
	logic [3:0] xo_v = 4'b0010;

	csc_clock_ctrl #(.CAL_SLOW_PERIODS(2)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.system_on_i(son), .branch_req_i(breq), .task_wr_i(twr), .task_wdata_i(twd),
		.slow_source_select_i(src), .slow_external_i(ext), .slow_bypass_i(byp),
		.cal_timer_interval_i(cal_timer_interval), .event_clr_i(eclr), .int_enable_i(inten),
		.fast_xtal_stable_i(xt_st), .slow_rc_ready_i(rc_rdy), .slow_xtal_ready_i(lx_rdy),
		.slow_clock_i(slck), .branch_en_o(ben), .fast_active_o(fact),
		.fast_internal_osc_en_o(fint), .fast_crystal_osc_en_o(fxt), .fast_src_xtal_o(fsx),
		.slow_rc_osc_en_o(rcen), .slow_crystal_osc_en_o(lxen), .slow_synth_en_o(syen),
		.slow_src_active_o(sact), .slow_src_copy_o(scopy), .slow_xtal_external_o(xext),
		.slow_xtal_bypass_o(xbyp), .slow_running_o(srun), .cal_busy_o(cbusy),
		.cal_timer_running_o(ctrun), .events_o(ev), .irq_o(irq));
	csc_osc_model u_osc (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.fast_crystal_osc_en_i(fxt), .slow_rc_osc_en_i(rcen), .slow_crystal_osc_en_i(lxen),
		.slow_synth_en_i(syen), .fast_xtal_stable_o(xt_st), .slow_rc_ready_o(rc_rdy),
		.slow_xtal_ready_o(lx_rdy), .slow_clock_o(slck));

	always #4 ref_clk_i = ~ref_clk_i;

	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : cyc

	task automatic trig(input int k, input logic [31:0] d);
		@(posedge ref_clk_i);
		twr[k] <= 1'b1;
		twd <= d;
		@(posedge ref_clk_i);
		twr <= '0;
		twd <= '0;
		cyc(4);
	endtask : trig

	task automatic clr(input int k);
		@(posedge ref_clk_i);
		eclr[k] <= 1'b1;
		@(posedge ref_clk_i);
		eclr <= '0;
		cyc(2);
	endtask : clr

	task automatic wait_ev(input int k, input int lim);
		for (int j = 0; j < lim && ev[k] !== 1'b1; j++) cyc(1);
		chk("event", 8'(ev[k]), 8'h1);
		cyc(2);
	endtask : wait_ev

	always @(posedge ref_clk_i) begin
		ncyc++;
		if (ncyc == 5000) begin
			n_fail++;
			results();
		end
	end

	initial begin
		repeat (2) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		cyc(3);
		chk("events_reset", 8'(ev), 8'h0);
		@(posedge ref_clk_i);
		son <= 1'b1;
		for (i = 0; i < 6 && fint !== 1'b1; i++) cyc(1);
		chk("fint_on_entry", 8'(fint), 8'h1);
		@(posedge ref_clk_i);
		breq <= 4'hf;
		cyc(3);
		chk("branches", 8'(ben), 8'h0f);
		chk("fast_active", 8'(fact), 8'h1);
		chk("fint_src", 8'(fint), 8'h1);
		chk("src_xtal", 8'(fsx), 8'h0);
		breq <= 4'h5;
		cyc(3);
		chk("branches", 8'(ben), 8'h05);
		breq <= 4'h0;
		cyc(3);
		chk("branches_off", 8'(ben), 8'h0);
		chk("fast_sleep", 8'(fact), 8'h0);
		$display("test fast branches done");
		trig(`CSC_TASK_XTAL_START, 32'h2);
		chk("xtal_refused", 8'(fxt), 8'h0);
		trig(`CSC_TASK_XTAL_START, 32'h1);
		chk("xtal_en", 8'(fxt), 8'h1);
		chk("xtal_ev_early", 8'(ev), 8'h0);
		wait_ev(`CSC_EV_XTAL_STARTED, 100);
		chk("src_xtal", 8'(fsx), 8'h1);
		inten <= 4'h1;
		cyc(2);
		chk("irq", 8'(irq), 8'h1);
		clr(`CSC_EV_XTAL_STARTED);
		chk("ev_cleared", 8'(ev), 8'h0);
		chk("irq_cleared", 8'(irq), 8'h0);
		$display("test fast crystal done");
		for (i = 0; i < 4; i++) begin
			// source set before start; only while stopped
			@(posedge ref_clk_i);
			src <= t_src[i];
			ext <= ext_v[i];
			byp <= byp_v[i];
			trig(`CSC_TASK_SLOW_START, 32'h1);
			if (t_src[i] == 2'h1) begin
				chk("rc_in_startup", 8'(rcen), 8'h1);
				chk("src_in_startup", 8'(sact), 8'h0);
			end
			wait_ev(`CSC_EV_SLOW_STARTED, 300);
			chk("running", 8'(srun), 8'h1);
			chk("src_active", 8'(sact), 8'(t_src[i]));
			chk("src_copy", 8'(scopy), 8'(t_src[i]));
			chk("external", 8'(xext), 8'(xo_v[i]));
			chk("bypass", 8'(xbyp), 8'(xo_v[i]));
			if (t_src[i] == 2'h2) chk("synth_fast", 8'(fact), 8'h1);
			chk("slow_xtal_en", 8'(lxen), 8'(t_src[i] == 2'h1));
			chk("synth_en", 8'(syen), 8'(t_src[i] == 2'h2));
			clr(`CSC_EV_SLOW_STARTED);
			trig(`CSC_TASK_SLOW_STOP, 32'h1);
			chk("stopped", 8'(srun), 8'h0);
		end
		$display("test slow sources done");
		@(posedge ref_clk_i);
		src <= 2'h0;
		ext <= 1'b0;
		byp <= 1'b0;
		trig(`CSC_TASK_SLOW_START, 32'h1);
		wait_ev(`CSC_EV_SLOW_STARTED, 300);
		trig(`CSC_TASK_CAL, 32'h1);
		chk("cal_busy", 8'(cbusy), 8'h1);
		chk("cal_fast", 8'(fact), 8'h1);
		wait_ev(`CSC_EV_CAL_DONE, 200);
		chk("cal_idle", 8'(cbusy), 8'h0);
		clr(`CSC_EV_SLOW_STARTED);
		clr(`CSC_EV_CAL_DONE);
		chk("cal_ev_cleared", 8'(ev), 8'h0);
		$display("test calibration done");
		// one timer task per slow period
		cyc(20);
		cal_timer_interval <= 7'h3;
		trig(`CSC_TASK_CT_START, 32'h1);
		chk("ct_run", 8'(ctrun), 8'h1);
		cyc(20);
		chk("ct_early", 8'(ev[`CSC_EV_CT_TIMEOUT]), 8'h0);
		wait_ev(`CSC_EV_CT_TIMEOUT, 100);
		chk("ct_self_stop", 8'(ctrun), 8'h0);
		clr(`CSC_EV_CT_TIMEOUT);
		cyc(20);
		cal_timer_interval <= 7'h7f;
		trig(`CSC_TASK_CT_START, 32'h1);
		cyc(20);
		trig(`CSC_TASK_CT_STOP, 32'h1);
		chk("ct_halt", 8'(ctrun), 8'h0);
		cyc(60);
		chk("ct_no_event", 8'(ev), 8'h0);
		$display("test timer done");
		trig(`CSC_TASK_XTAL_STOP, 32'h1);
		chk("xtal_off", 8'(fxt), 8'h0);
		chk("src_int", 8'(fsx), 8'h0);
		@(posedge ref_clk_i);
		breq <= 4'hf;
		son <= 1'b0;
		cyc(4);
		chk("off_branches", 8'(ben), 8'h0);
		chk("off_rc", 8'(rcen), 8'h0);
		chk("off_slow", 8'(srun), 8'h0);
		$display("test off mode done");
		results();
	end
endmodule : clock_source_controller_tb
